// file: include/ppm_pkg.sv
// Constants, field positions and reset values of the port PHY/MAC
// mode register bank.
// Assumes a 32-bit APB slave, one aligned word for each register.
package ppm_pkg;
   localparam int ADDR_W = 12;
   localparam int DATA_W = 32;
   // Register indices; the byte address is four times the index
   localparam logic [9:0] IDX_XOVER = 10'h138;
   localparam logic [9:0] IDX_SPECIAL = 10'h13C;
   localparam logic [9:0] IDX_PHYCTL = 10'h13E;
   localparam logic [9:0] IDX_MACCTL = 10'h300;
   localparam logic [9:0] IDX_MACCTL1 = 10'h301;
   localparam logic [ADDR_W-1:0] ADR_XOVER = {IDX_XOVER, 2'b00};
   localparam logic [ADDR_W-1:0] ADR_SPECIAL = {IDX_SPECIAL, 2'b00};
   localparam logic [ADDR_W-1:0] ADR_PHYCTL = {IDX_PHYCTL, 2'b00};
   localparam logic [ADDR_W-1:0] ADR_MACCTL = {IDX_MACCTL, 2'b00};
   localparam logic [ADDR_W-1:0] ADR_MACCTL1 = {IDX_MACCTL1, 2'b00};
   // Field positions
   localparam int XO_MANUAL_CROSSOVER_SELECT = 7;
   localparam int XO_SWAP_OFF = 6;
   localparam int SP_LED_FIX = 9;
   localparam int PC_JAB_EN = 9;
   localparam int MC_DUPLEX = 6;
   localparam int MC_TXFC = 5;
   localparam int MC_SPD100 = 4;
   localparam int MC_RXFC = 3;
   localparam int M1_GIG_SEL = 6;
   // Values after reset; flow-control and gigabit bits come from straps
   localparam logic [15:0] RST_XOVER = 16'h0000;
   localparam logic [15:0] RST_SPECIAL = 16'hF800;
   localparam logic [15:0] RST_PHYCTL = 16'h0300;
   localparam logic [7:0] RST_MACCTL = 8'h50;
   localparam logic [7:0] RST_MACCTL1 = 8'h08;
   // Bits that software may change; the rest are read-only
   localparam logic [15:0] WM_PHYCTL = 16'hF382;
   localparam logic [7:0] WM_MACCTL = 8'h7F;
   // Resolved or selected line speed
   typedef enum logic [1:0] {
      SPD_10 = 2'b00,
      SPD_100 = 2'b01,
      SPD_1000 = 2'b10
   } ppm_speed_e;
endpackage

// file: include/ppm_cfg_if.sv
// Carrier between the register bank and its copper and MAC port logic.
// Assumes one driver per signal, as the modports give.
`timescale 1ns/1ps
interface ppm_cfg_if;
   logic swap_off;
   logic manual_crossover_select;
   logic jabber_en;
   logic led_fix;
   logic mac_fdx;
   logic mac_txfc;
   logic mac_rxfc;
   logic mac_spd100;
   logic gig_sel;
   logic [4:0] phy_status;
   modport regs (output swap_off, manual_crossover_select, jabber_en, led_fix, mac_fdx,
      mac_txfc, mac_rxfc, mac_spd100, gig_sel, input phy_status);
   modport phy (input swap_off, manual_crossover_select, jabber_en, led_fix,
      output phy_status);
   modport mac (input mac_fdx, mac_txfc, mac_rxfc, mac_spd100, gig_sel);
endinterface

// file: hdl/ppm_phy_port.sv
// Copper port mode logic: crossover choice, jabber gate, LED fix and
// the resolved link status seen by software.
// Assumes status inputs are synchronous to clk_in.
`timescale 1ns/1ps
module ppm_phy_port (
   input wire logic clk_in,
   input wire logic rst_in,
   ppm_cfg_if.phy cfg,
   input wire logic auto_mdi_in,
   input wire ppm_pkg::ppm_speed_e speed_in,
   input wire logic full_dup_in,
   input wire logic master_in,
   output logic mdi_mode_out,
   output logic auto_en_out,
   output logic jabber_en_out,
   output logic led_fix_out
);
   import ppm_pkg::*;

   typedef struct packed {
      logic mdi;
      logic auto_en;
      logic jab;
      logic led;
      logic [4:0] stat;
   } ppm_phy_s;

   ppm_phy_s s_q;
   ppm_phy_s s_d;

   // Pair assignment, jabber gate and one-hot status
   always_comb
   begin
      s_d = s_q;
      s_d.auto_en = ~cfg.swap_off; // R3
      s_d.mdi = cfg.swap_off ? cfg.manual_crossover_select : auto_mdi_in; // R1 R2
      s_d.jab = cfg.jabber_en; // R5
      s_d.led = cfg.led_fix;
      s_d.stat = {speed_in == SPD_1000, speed_in == SPD_100,
         speed_in == SPD_10, full_dup_in, master_in}; // R6 R7
   end

   // State register
   always_ff @(posedge clk_in or posedge rst_in)
   begin
      if (rst_in)
      begin
         s_q.mdi <= 1'b0;
         s_q.auto_en <= ~RST_XOVER[XO_SWAP_OFF];
         s_q.jab <= RST_PHYCTL[PC_JAB_EN];
         s_q.led <= RST_SPECIAL[SP_LED_FIX];
         s_q.stat <= 5'h00;
      end
      else
      begin
         s_q <= s_d;
      end
   end

   assign mdi_mode_out = s_q.mdi;
   assign auto_en_out = s_q.auto_en;
   assign jabber_en_out = s_q.jab;
   assign led_fix_out = s_q.led;
   assign cfg.phy_status = s_q.stat;
endmodule

// file: hdl/ppm_mac_port.sv
// External MAC port mode logic: speed, duplex and pause gating.
// Assumes pause requests are synchronous to clk_in.
`timescale 1ns/1ps
module ppm_mac_port (
   input wire logic clk_in,
   input wire logic rst_in,
   ppm_cfg_if.mac cfg,
   input wire logic tx_pause_req_in,
   input wire logic rx_pause_req_in,
   output ppm_pkg::ppm_speed_e speed_out,
   output logic full_dup_out,
   output logic tx_pause_out,
   output logic rx_pause_act_out
);
   import ppm_pkg::*;

   typedef struct packed {
      ppm_speed_e spd;
      logic fdx;
      logic tx;
      logic rx;
   } ppm_mac_s;

   ppm_mac_s s_q;
   ppm_mac_s s_d;

   // Speed choice: 10/100 bit only counts off gigabit
   always_comb
   begin
      s_d = s_q;
      if (!cfg.gig_sel)
      begin
         s_d.spd = SPD_1000; // R13 R14
      end
      else
      begin
         s_d.spd = cfg.mac_spd100 ? SPD_100 : SPD_10; // R12 R14
      end
      s_d.fdx = cfg.mac_fdx; // R8
      s_d.tx = tx_pause_req_in & cfg.mac_txfc; // R9
      s_d.rx = rx_pause_req_in & cfg.mac_rxfc; // R10
   end

   // State register
   always_ff @(posedge clk_in or posedge rst_in)
   begin
      if (rst_in)
      begin
         s_q.spd <= SPD_1000;
         s_q.fdx <= RST_MACCTL[MC_DUPLEX];
         s_q.tx <= 1'b0;
         s_q.rx <= 1'b0;
      end
      else
      begin
         s_q <= s_d;
      end
   end

   assign speed_out = s_q.spd;
   assign full_dup_out = s_q.fdx;
   assign tx_pause_out = s_q.tx;
   assign rx_pause_act_out = s_q.rx;
endmodule

// file: hdl/ppm_regs.sv
// Per-port PHY and external MAC mode register bank behind an APB slave.
// Assumes APB master signals synchronous to clk_in, straps stable
// around reset release, and one copper and one MAC port behind it.
//
// Function
// R1: Manual mode: select 1 MDI, 0 MDI-X
// R2: Select bit ignored while auto crossover on
// R3: Disable bit resets 0; 1 stops auto
// R4: Software sets LED fix bit for single-LED
// R5: Jabber counter enabled at reset, bit gates
// R6: Resolved speed shown as one-hot status
// R7: Duplex and master/slave shown read-only
// R8: MAC duplex resets full; 0 gives half
// R9: Transmit pause only while enable bit set
// R10: Received pause honoured only while enabled
// R11: Flow-control enable defaults from strap pin
// R12: Off gigabit, 10/100 bit picks speed
// R13: 10/100 bit ignored at gigabit speed
// R14: Gigabit select 0 means 1000 Mb/s
// R15: Reserved bits: RO fixed, RW just stored
`timescale 1ns/1ps
module ppm_regs (
   input wire logic clk_in,
   input wire logic rst_in,
   // APB slave
   input wire logic psel_in,
   input wire logic penable_in,
   input wire logic pwrite_in,
   input wire logic [ppm_pkg::ADDR_W-1:0] paddr_in,
   input wire logic [ppm_pkg::DATA_W-1:0] pwdata_in,
   output logic [ppm_pkg::DATA_W-1:0] prdata_out,
   output logic pready_out,
   output logic pslverr_out,
   // Straps, caught once after reset release
   input wire logic flow_control_strap_pin_in,
   input wire logic gig_strap_in,
   // Copper port side
   input wire logic auto_mdi_in,
   input wire ppm_pkg::ppm_speed_e phy_speed_in,
   input wire logic phy_full_dup_in,
   input wire logic phy_master_in,
   output logic mdi_mode_out,
   output logic auto_xover_en_out,
   output logic jabber_en_out,
   output logic single_led_fix_out,
   // External MAC port side
   input wire logic mac_tx_pause_req_in,
   input wire logic mac_rx_pause_req_in,
   output ppm_pkg::ppm_speed_e mac_speed_out,
   output logic mac_full_dup_out,
   output logic mac_tx_pause_out,
   output logic mac_rx_pause_act_out
);
   import ppm_pkg::*;

   // Register layout as software sees it, in the low half of each word:
   //   crossover_control
   //      bit 7     manual pair select, 1 MDI, 0 MDI-X
   //      bit 6     auto crossover off; select counts only when set
   //      others    stored, no effect
   //   port_special_control
   //      bit 9     single-LED workaround, driven out as stored
   //      others    stored, no effect
   //   phy_control_status
   //      bit 9     jabber counter enable
   //      bits 6:4  resolved speed, one-hot 1000/100/10
   //      bit 3     resolved duplex, bit 2 gigabit master role
   //      bits 11:10 and 0 read zero; the rest stored, no effect
   //   ext_mac_port_control_a
   //      bit 6     duplex, bit 4 100 over 10 when not gigabit
   //      bits 5, 3 transmit and receive pause enables
   //      bit 7 reads zero; bits 2:0 stored, no effect
   //   companion control
   //      bit 6     gigabit select, 0 runs at 1000
   //      others    stored, no effect
   // Words above the low half always read zero. The pause enables and
   // the gigabit select take their strap levels on the first edge after
   // reset release; a write in that same edge would still win.

   // Whole state of the bank
   typedef struct packed {
      // Software-visible registers, low half of each word only
      logic [15:0] xover;
      logic [15:0] special;
      logic [15:0] phyctl;
      logic [7:0] macctl;
      logic [7:0] macctl1;
      // Straps are caught once, on the first edge after reset
      logic strap_done;
      // Bus answer, held in flops so the outputs come from registers
      logic pready;
      logic pslverr;
      logic [DATA_W-1:0] prdata;
   } ppm_regs_s;

   ppm_regs_s s_q;
   ppm_regs_s s_d;

   logic setup;
   logic access;
   logic hit;
   logic [15:0] rdata;
   logic [15:0] phy_rd;
   logic [7:0] mac_rd;
   logic wr_ok;
   logic [15:0] phyctl_wr;
   logic [7:0] macctl_wr;

   ppm_cfg_if cfg ();

   // Copper port logic
   ppm_phy_port u_phy (
      .clk_in(clk_in),
      .rst_in(rst_in),
      .cfg(cfg.phy),
      .auto_mdi_in(auto_mdi_in),
      .speed_in(phy_speed_in),
      .full_dup_in(phy_full_dup_in),
      .master_in(phy_master_in),
      .mdi_mode_out(mdi_mode_out),
      .auto_en_out(auto_xover_en_out),
      .jabber_en_out(jabber_en_out),
      .led_fix_out(single_led_fix_out)
   );

   // External MAC port logic
   ppm_mac_port u_mac (
      .clk_in(clk_in),
      .rst_in(rst_in),
      .cfg(cfg.mac),
      .tx_pause_req_in(mac_tx_pause_req_in),
      .rx_pause_req_in(mac_rx_pause_req_in),
      .speed_out(mac_speed_out),
      .full_dup_out(mac_full_dup_out),
      .tx_pause_out(mac_tx_pause_out),
      .rx_pause_act_out(mac_rx_pause_act_out)
   );

   // Control fields handed to the port logic
   assign cfg.swap_off = s_q.xover[XO_SWAP_OFF]; // R3
   assign cfg.manual_crossover_select = s_q.xover[XO_MANUAL_CROSSOVER_SELECT]; // R1
   assign cfg.jabber_en = s_q.phyctl[PC_JAB_EN]; // R5
   assign cfg.led_fix = s_q.special[SP_LED_FIX];
   assign cfg.mac_fdx = s_q.macctl[MC_DUPLEX]; // R8
   assign cfg.mac_txfc = s_q.macctl[MC_TXFC]; // R9
   assign cfg.mac_rxfc = s_q.macctl[MC_RXFC]; // R10
   assign cfg.mac_spd100 = s_q.macctl[MC_SPD100]; // R12
   assign cfg.gig_sel = s_q.macctl1[M1_GIG_SEL]; // R14

   // Read views: fixed reserved bits and live status merged in
   assign phy_rd = {
      s_q.phyctl[15:12], // Stored, no effect
      2'b00, // R15
      s_q.phyctl[9:7], // Jabber enable and a stored pair
      cfg.phy_status, // R6 R7
      s_q.phyctl[1], // Stored, no effect
      1'b0 // R15
   };
   assign mac_rd = {1'b0, s_q.macctl[6:0]}; // R15

   // Timing of one transfer as the slave sees it:
   //   setup edge   address decoded, read word captured, pready raised
   //   access edge  write committed, pready and pslverr dropped
   // No wait states are ever inserted, so pready is a one-cycle pulse.
   // The read word is captured at setup rather than muxed live, which
   // keeps prdata_out a flop; the price is that status reads show the
   // port as it stood one edge before the setup edge.
   // A setup that follows an access at once is decoded as any other.
   assign setup = psel_in & ~penable_in;
   assign access = psel_in & penable_in & s_q.pready;
   // A refused address raised pslverr at setup and so stores nothing
   assign wr_ok = access & pwrite_in & ~s_q.pslverr;

   // Per-bit write merge: a writable bit takes the bus, a read-only
   // bit keeps what it holds, whatever software sends
   for (genvar b = 0; b < 16; b++)
   begin : g_merge
      assign phyctl_wr[b] = WM_PHYCTL[b] ? pwdata_in[b] : s_q.phyctl[b];
      if (b < 8)
      begin : g_mac
         assign macctl_wr[b] = WM_MACCTL[b] ? pwdata_in[b] : s_q.macctl[b];
      end
   end

   // Address decode and read mux
   always_comb
   begin
      hit = 1'b1;
      rdata = 16'h0000;
      case (paddr_in)
         ADR_XOVER:
         begin
            rdata = s_q.xover;
         end
         ADR_SPECIAL:
         begin
            rdata = s_q.special;
         end
         ADR_PHYCTL:
         begin
            rdata = phy_rd;
         end
         ADR_MACCTL:
         begin
            rdata = {8'h00, mac_rd};
         end
         ADR_MACCTL1:
         begin
            rdata = {8'h00, s_q.macctl1};
         end
         default:
         begin
            hit = 1'b0;
         end
      endcase
   end

   // Next state: strap load, bus answer and register writes
   always_comb
   begin
      s_d = s_q;
      // Straps are caught on the first edge after release, not under
      // reset, so the asynchronous reset only loads constants. Until
      // that edge the port logic sees the reset constants: gigabit
      // speed and both pause enables off, which is the safe side.
      if (!s_q.strap_done)
      begin
         s_d.strap_done = 1'b1;
         s_d.macctl[MC_TXFC] = flow_control_strap_pin_in; // R11
         s_d.macctl[MC_RXFC] = flow_control_strap_pin_in; // R11
         s_d.macctl1[M1_GIG_SEL] = gig_strap_in;
      end
      // Setup phase: answer is prepared for the first access cycle
      if (setup)
      begin
         s_d.pready = 1'b1;
         s_d.pslverr = ~hit;
         if (!pwrite_in && hit)
         begin
            s_d.prdata = {16'h0000, rdata};
         end
         else
         begin
            s_d.prdata = '0;
         end
      end
      else if (access)
      begin
         s_d.pready = 1'b0;
         s_d.pslverr = 1'b0;
      end
      // Writes land at the edge that completes the access phase
      if (wr_ok)
      begin
         case (paddr_in)
            ADR_XOVER:
            begin
               s_d.xover = pwdata_in[15:0]; // R1 R2 R3 R15
            end
            ADR_SPECIAL:
            begin
               s_d.special = pwdata_in[15:0]; // R15
            end
            ADR_PHYCTL:
            begin
               s_d.phyctl = phyctl_wr; // R5 R15
            end
            ADR_MACCTL:
            begin
               s_d.macctl = macctl_wr; // R8 R12 R15
            end
            ADR_MACCTL1:
            begin
               s_d.macctl1 = pwdata_in[7:0]; // R13 R14
            end
            default:
            begin
               s_d.pslverr = 1'b0;
            end
         endcase
      end
   end

   // State register; reset takes constants only
   always_ff @(posedge clk_in or posedge rst_in)
   begin
      if (rst_in)
      begin
         s_q.xover <= RST_XOVER; // R3
         s_q.special <= RST_SPECIAL;
         s_q.phyctl <= RST_PHYCTL; // R5
         s_q.macctl <= RST_MACCTL; // R8 R12
         s_q.macctl1 <= RST_MACCTL1;
         s_q.strap_done <= 1'b0;
         s_q.pready <= 1'b0;
         s_q.pslverr <= 1'b0;
         s_q.prdata <= '0;
      end
      else
      begin
         s_q <= s_d;
      end
   end

   // Bus outputs straight from the state register
   assign prdata_out = s_q.prdata;
   assign pready_out = s_q.pready;
   assign pslverr_out = s_q.pslverr;
endmodule

// file: test/ppm_regs_asserts.sv
// Checker for the port PHY/MAC mode register bank, bound to ppm_regs.
// Assumes only the top-level ports; internal state is not visible.
`timescale 1ns/1ps
module ppm_regs_asserts (
   input wire logic clk_in,
   input wire logic rst_in,
   input wire logic psel_in,
   input wire logic penable_in,
   input wire logic pwrite_in,
   input wire logic [ppm_pkg::ADDR_W-1:0] paddr_in,
   input wire logic [ppm_pkg::DATA_W-1:0] prdata_out,
   input wire logic pready_out,
   input wire logic pslverr_out,
   input wire logic auto_mdi_in,
   input wire logic phy_full_dup_in,
   input wire logic phy_master_in,
   input wire logic mdi_mode_out,
   input wire logic auto_xover_en_out,
   input wire logic jabber_en_out,
   input wire logic single_led_fix_out,
   input wire logic mac_tx_pause_req_in,
   input wire logic mac_rx_pause_req_in,
   input wire ppm_pkg::ppm_speed_e mac_speed_out,
   input wire logic mac_full_dup_out,
   input wire logic mac_tx_pause_out,
   input wire logic mac_rx_pause_act_out
);
   import ppm_pkg::*;
   logic [1:0] up_q;
   logic wr_acc;
   logic rd_phy;
   // Cycles since reset; strap loading moves outputs at first
   always_ff @(posedge clk_in or posedge rst_in)
   begin
      if (rst_in)
         up_q <= 2'h0;
      else if (up_q != 2'h3)
         up_q <= up_q + 2'h1;
   end
   // Write access edge and read of the PHY control word
   assign wr_acc = psel_in && penable_in && pwrite_in && pready_out;
   assign rd_phy = pready_out && !pwrite_in && paddr_in == ADR_PHYCTL;
   default clocking cb @(posedge clk_in); endclocking
   default disable iff (rst_in);
   AST_APB_READY: assert property (psel_in && !penable_in |=> pready_out)
      else $error("ready missing after setup");
   AST_ERR_WITH_READY: assert property (pslverr_out |-> pready_out)
      else $error("error without ready");
   AST_AUTO_FOLLOW: assert property (
      up_q == 2'h3 && auto_xover_en_out |-> mdi_mode_out == $past(auto_mdi_in))
      else $error("auto pair mode not following detector");
   AST_MANUAL_HOLD: assert property (up_q == 2'h3 && !auto_xover_en_out &&
      !$past(wr_acc) && !$past(wr_acc, 2) |-> $stable(mdi_mode_out))
      else $error("manual pair mode moved without write");
   AST_TX_GATE: assert property (
      mac_tx_pause_out |-> $past(mac_tx_pause_req_in))
      else $error("transmit pause without request");
   AST_RX_GATE: assert property (
      mac_rx_pause_act_out |-> $past(mac_rx_pause_req_in))
      else $error("receive pause without request");
   AST_MAC_WRITE_ONLY: assert property (up_q == 2'h3 &&
      !$past(wr_acc) && !$past(wr_acc, 2)
      |-> $stable(mac_speed_out) && $stable(mac_full_dup_out))
      else $error("MAC mode moved without write");
   AST_PHY_WRITE_ONLY: assert property (up_q == 2'h3 &&
      !$past(wr_acc) && !$past(wr_acc, 2)
      |-> $stable(jabber_en_out) && $stable(single_led_fix_out))
      else $error("copper mode moved without write");
   AST_SPEED_ONEHOT: assert property (rd_phy |-> $onehot(prdata_out[6:4]))
      else $error("speed status not one-hot");
   AST_DUPLEX_ROLE: assert property (rd_phy && up_q == 2'h3 |->
      prdata_out[3:2] == $past({phy_full_dup_in, phy_master_in}, 2))
      else $error("duplex or role status wrong");
   AST_MAC_RESERVED: assert property (pready_out && !pwrite_in &&
      paddr_in == ADR_MACCTL |-> prdata_out[31:7] == 25'h0)
      else $error("MAC control reserved bits not zero");
   COV_XOVER_WRITE: cover property (wr_acc && paddr_in == ADR_XOVER);
   COV_REFUSED: cover property (pslverr_out);
   COV_TX_PAUSE: cover property (mac_tx_pause_out);
endmodule
bind ppm_regs ppm_regs_asserts u_chk (.*);

// file: test/tb.sv
// Self-checking bench for the port PHY/MAC mode register bank.
// Assumes an APB slave answering in the first access cycle after the setup edge, with no wait states.
`timescale 1ns/1ps
module tb;
   import ppm_pkg::*;
   logic clk_in, rst_in, psel_in, penable_in, pwrite_in, pready_out;
   logic [ADDR_W-1:0] paddr_in;
   logic [DATA_W-1:0] pwdata_in, prdata_out, rd;
   logic pslverr_out, err_seen, auto_mdi_in, gig_strap_in;
   logic flow_control_strap_pin_in, phy_full_dup_in, phy_master_in;
   ppm_speed_e phy_speed_in, mac_speed_out;
   logic mdi_mode_out, auto_xover_en_out, jabber_en_out;
   logic single_led_fix_out, mac_tx_pause_req_in, mac_rx_pause_req_in;
   logic mac_full_dup_out, mac_tx_pause_out, mac_rx_pause_act_out;
   logic [15:0] st;
   int err_total = 0;
   int checks_done = 0;
   int cyc = 0;

   ppm_regs u_dut (.*);

   // 40 MHz clock
   initial
   begin
      clk_in = 1'b0;
      forever #12.5 clk_in = ~clk_in;
   end

   task automatic summarize();
      if (err_total == 0 && checks_done > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask

   task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
      checks_done++;
      if (got !== exp)
      begin
         err_total++;
         $display("[FAIL] %0t got %h expected %h", $time, got, exp);
      end
   endtask

   // One APB transfer; a slave that never answers meets the hang guard
   task automatic apb(input logic wr, input logic [ADDR_W-1:0] a,
      input logic [DATA_W-1:0] d);
      int n;
      n = 0;
      psel_in <= 1'b1;
      pwrite_in <= wr;
      paddr_in <= a;
      pwdata_in <= d;
      @(posedge clk_in);
      penable_in <= 1'b1;
      do
      begin
         @(posedge clk_in);
         n++;
      end
      while (pready_out !== 1'b1);
      rd = prdata_out;
      err_seen = pslverr_out;
      // The slave never inserts wait states
      cmp(32'(n), 32'h1);
      psel_in <= 1'b0;
      penable_in <= 1'b0;
      @(posedge clk_in);
   endtask

   task automatic rdc(input logic [ADDR_W-1:0] a, input logic [31:0] e);
      apb(1'b0, a, 32'h0);
      cmp(rd, e);
   endtask

   // Port outputs lag the register write by one flop
   task automatic settle();
      repeat (2) @(posedge clk_in);
   endtask

   task automatic do_reset(input logic fc, input logic g);
      rst_in <= 1'b1;
      flow_control_strap_pin_in <= fc;
      gig_strap_in <= g;
      repeat (2) @(posedge clk_in);
      rst_in <= 1'b0;
      repeat (2) @(posedge clk_in);
   endtask

   task automatic t_reset();
      rdc(ADR_XOVER, 32'h0);
      rdc(ADR_SPECIAL, 32'hF800);
      rdc(ADR_PHYCTL, 32'h0348);
      rdc(ADR_MACCTL, 32'h50);
      rdc(ADR_MACCTL1, 32'h48);
      cmp({31'h0, auto_xover_en_out}, 32'h1);
      cmp({31'h0, jabber_en_out}, 32'h1);
      cmp({31'h0, mac_full_dup_out}, 32'h1);
      cmp({30'h0, mac_speed_out}, {30'h0, SPD_100});
   endtask

   // Detector is driven opposite to the manual choice to tell them apart
   task automatic t_xover();
      logic m, s;
      for (int i = 0; i < 4; i++)
      begin
         {m, s} = 2'(i);
         auto_mdi_in <= ~m;
         apb(1'b1, ADR_XOVER, {16'h0, 8'hA5, m, s, 6'h2A});
         settle();
         cmp({31'h0, mdi_mode_out}, {31'h0, s ? m : ~m});
         cmp({31'h0, auto_xover_en_out}, {31'h0, ~s});
         rdc(ADR_XOVER, {16'h0, 8'hA5, m, s, 6'h2A});
      end
   endtask

   task automatic t_status();
      for (int s = 0; s < 3; s++)
      begin
         phy_speed_in <= ppm_speed_e'(s);
         phy_full_dup_in <= s[0];
         phy_master_in <= ~s[0];
         settle();
         st = 16'h0300 | (16'h0010 << s) | {12'h0, s[0], ~s[0], 2'b00};
         rdc(ADR_PHYCTL, {16'h0, st});
      end
   endtask

   task automatic t_phy_bits();
      apb(1'b1, ADR_PHYCTL, 32'hFFFFFDFF);
      settle();
      cmp({31'h0, jabber_en_out}, 32'h0);
      rdc(ADR_PHYCTL, {16'h0, 16'hF182 | (st & 16'h007C)});
      apb(1'b1, ADR_PHYCTL, 32'h0200);
      apb(1'b1, ADR_SPECIAL, 32'h0200);
      settle();
      cmp({31'h0, jabber_en_out}, 32'h1);
      cmp({31'h0, single_led_fix_out}, 32'h1);
      rdc(ADR_SPECIAL, 32'h0200);
      apb(1'b1, ADR_SPECIAL, 32'h0);
      settle();
      cmp({31'h0, single_led_fix_out}, 32'h0);
   endtask

   task automatic t_mac();
      logic [3:0] b;
      ppm_speed_e sp;
      mac_tx_pause_req_in <= 1'b1;
      mac_rx_pause_req_in <= 1'b1;
      for (int i = 0; i < 16; i++)
      begin
         b = 4'(i);
         apb(1'b1, ADR_MACCTL, {24'h0, 1'b1, b[0], b[1], b[2], b[3], 3'h5});
         apb(1'b1, ADR_MACCTL1, {24'h0, 1'b0, b[0], 6'h08});
         settle();
         sp = b[0] ? (b[2] ? SPD_100 : SPD_10) : SPD_1000;
         cmp({31'h0, mac_full_dup_out}, {31'h0, b[0]});
         cmp({31'h0, mac_tx_pause_out}, {31'h0, b[1]});
         cmp({31'h0, mac_rx_pause_act_out}, {31'h0, b[3]});
         cmp({30'h0, mac_speed_out}, {30'h0, sp});
      end
      rdc(ADR_MACCTL, 32'h7D);
   endtask

   task automatic t_unmapped();
      apb(1'b1, 12'h004, 32'hFFFFFFFF);
      cmp({31'h0, err_seen}, 32'h1);
      apb(1'b0, 12'h004, 32'h0);
      cmp({31'h0, err_seen}, 32'h1);
      cmp(rd, 32'h0);
   endtask

   // Second reset with the other strap levels
   task automatic t_strap();
      do_reset(1'b1, 1'b0);
      rdc(ADR_MACCTL, 32'h78);
      rdc(ADR_MACCTL1, 32'h08);
      cmp({30'h0, mac_speed_out}, {30'h0, SPD_1000});
      cmp({31'h0, mac_tx_pause_out}, 32'h1);
      cmp({31'h0, mac_rx_pause_act_out}, 32'h1);
      mac_tx_pause_req_in <= 1'b0;
      settle();
      cmp({31'h0, mac_tx_pause_out}, 32'h0);
   endtask

   // Hang guard well above the few hundred cycles the run needs
   always @(posedge clk_in)
   begin
      cyc++;
      if (cyc == 20000)
      begin
         err_total++;
         summarize();
      end
   end

   initial
   begin
      rst_in = 1'b1;
      {psel_in, penable_in, pwrite_in, paddr_in, pwdata_in} = '0;
      {flow_control_strap_pin_in, gig_strap_in, auto_mdi_in} = 3'h1;
      {mac_tx_pause_req_in, mac_rx_pause_req_in, phy_master_in} = 3'h0;
      phy_speed_in = SPD_1000;
      phy_full_dup_in = 1'b1;
      do_reset(1'b0, 1'b1);
      t_reset();
      t_xover();
      t_status();
      t_phy_bits();
      t_mac();
      t_unmapped();
      t_strap();
      summarize();
   end
endmodule
